// File: logic/irc_top.sv
// Interrupt request controller: pin filter, detection, ranking, exceptions
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module irc_top
	import irc_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic [NUM_EXT-1:0] ext_req_pin_in,
	input wire logic nmi_pin_in,
	input wire logic osc_stop_in,
	input wire logic independent_watchdog_err_in,
	input wire logic volt_mon1_in,
	input wire logic volt_mon2_in,
	input wire logic [NUM_PER-1:0] periph_req_in,
	input wire logic trap_instr_in,
	input wire logic [3:0] trap_num_in,
	input wire logic breakpoint_trap_instr_in,
	input wire logic undef_instr_in,
	input wire logic priv_instr_in,
	input wire logic user_mode_in,
	output logic irq_out,
	output irc_irq_req_t irq_req_out,
	output irc_exc_req_t nmi_req_out,
	output irc_exc_req_t exc_req_out
);

	// ==========================================================
	// Register bus
	logic bus_ack;
	logic wr_en;
	logic [31:0] wmask;
	logic [31:0] wbits;
	logic [31:0] next_rdata;

	logic [NUM_NMI-1:0] nmi_flags;
	logic nmi_rise;
	logic [1:0] div_sel;
	logic [NUM_PIN-1:0] filt_en;
	logic [2*NUM_EXT-1:0] irq_mode;
	logic [NUM_SRC-1:0] pend;
	logic [NUM_SRC-1:0] enable;
	logic [3:0] prio [NUM_SRC];
	logic [3:0] exc_flags;
	irc_irq_req_t next_irq;

	// One wait cycle, then answer
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~bus_ack;
	assign wr_en = avs_write_in & bus_ack;
	assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
		{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
	assign wbits = avs_writedata_in & wmask;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= (avs_read_in | avs_write_in) & ~bus_ack;
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (avs_address_in)
			OFS_NMI_FLAGS: next_rdata[NUM_NMI-1:0] = nmi_flags;
			OFS_CFG: begin
				next_rdata[CFG_NMI_RISE] = nmi_rise;
				next_rdata[CFG_DIV_LSB +: 2] = div_sel;
			end
			OFS_FILT_EN: next_rdata[NUM_PIN-1:0] = filt_en;
			OFS_IRQ_MODE: next_rdata[2*NUM_EXT-1:0] = irq_mode;
			OFS_PEND: next_rdata[NUM_SRC-1:0] = pend;
			OFS_ENABLE: next_rdata[NUM_SRC-1:0] = enable;
			OFS_PRIO0: begin
				for (int i = 0; i < 8; i++) begin
					next_rdata[4*i +: 4] = prio[i];
				end
			end
			OFS_PRIO1: begin
				for (int i = 0; i < 8; i++) begin
					next_rdata[4*i +: 4] = prio[8+i];
				end
			end
			OFS_PRIO2: next_rdata[3:0] = prio[SW_SRC];
			OFS_ACTIVE: begin
				next_rdata[4:0] = irq_req_out.id;
				next_rdata[ACT_LVL_LSB +: 4] = irq_req_out.level;
				next_rdata[ACT_VALID] = irq_req_out.valid;
			end
			OFS_EXC_FLAGS: next_rdata[3:0] = exc_flags;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Unmapped reads answer zero, unmapped writes vanish
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in & ~bus_ack) begin
			avs_readdata_out <= next_rdata;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			nmi_rise <= 1'b0;
			div_sel <= 2'h0;
			filt_en <= '0;
			irq_mode <= {NUM_EXT{RST_MODE}};
			enable <= '0;
		end else if (wr_en) begin
			case (avs_address_in)
				OFS_CFG: begin
					if (avs_byteenable_in[0]) begin
						nmi_rise <= avs_writedata_in[CFG_NMI_RISE];
						div_sel <= avs_writedata_in[CFG_DIV_LSB +: 2];
					end
				end
				OFS_FILT_EN: filt_en <= (filt_en & ~wmask[NUM_PIN-1:0])
					| wbits[NUM_PIN-1:0];
				OFS_IRQ_MODE: irq_mode <= (irq_mode & ~wmask[15:0])
					| wbits[15:0];
				OFS_ENABLE: enable <= (enable & ~wmask[NUM_SRC-1:0])
					| wbits[NUM_SRC-1:0];
				default: ;
			endcase
		end
	end

	// Priority words: eight sources per word, the software source alone in the third, four bits each
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < NUM_SRC; i++) begin
				prio[i] <= RST_PRIO;
			end
		end else if (wr_en) begin
			for (int i = 0; i < 8; i++) begin
				if (wmask[4*i]) begin
					if (avs_address_in == OFS_PRIO0) begin
						prio[i] <= avs_writedata_in[4*i +: 4];
					end
					if (avs_address_in == OFS_PRIO1) begin
						prio[8+i] <= avs_writedata_in[4*i +: 4];
					end
				end
			end
			if (avs_address_in == OFS_PRIO2 && wmask[0]) begin
				prio[SW_SRC] <= avs_writedata_in[3:0];
			end
		end
	end

	// ==========================================================
	// Pin synchronisers and digital filter
	logic [NUM_PIN-1:0] pin_meta;
	logic [NUM_PIN-1:0] pin_sync;
	logic [NUM_PIN-1:0] pin_filt;
	logic [NUM_PIN-1:0] pin_lvl;
	logic [NUM_PIN-1:0] pin_prev;
	logic [5:0] div_cnt;
	logic [5:0] div_lim;
	logic samp_tick;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_meta <= {NUM_PIN{1'b1}};
			pin_sync <= {NUM_PIN{1'b1}};
		end else begin
			pin_meta <= {nmi_pin_in, ext_req_pin_in};
			pin_sync <= pin_meta;
		end
	end

	always_comb begin
		case (div_sel)
			2'h0: div_lim = DIV_LIM_1;
			2'h1: div_lim = DIV_LIM_8;
			2'h2: div_lim = DIV_LIM_32;
			default: div_lim = DIV_LIM_64;
		endcase
	end

	assign samp_tick = (div_cnt >= div_lim);

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_cnt <= 6'h00;
		end else if (samp_tick) begin
			div_cnt <= 6'h00;
		end else begin
			div_cnt <= div_cnt + 6'h01;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_PIN; g++) begin : g_filt
			logic [FILT_SAMPLES-2:0] hist;
			logic [FILT_SAMPLES-1:0] win;
			assign win = {hist, pin_sync[g]};
			always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					hist <= '1;
					pin_filt[g] <= 1'b1;
				end else if (samp_tick) begin
					hist <= win[FILT_SAMPLES-2:0];
					// Three matching samples move the output
					if (&win || ~|win) begin
						pin_filt[g] <= pin_sync[g];
					end
				end
			end
			// Bypass feeds the synchronised raw level
			assign pin_lvl[g] = filt_en[g] ? pin_filt[g] : pin_sync[g];
		end
	endgenerate

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_prev <= {NUM_PIN{1'b1}};
		end else begin
			pin_prev <= pin_lvl;
		end
	end

	// ==========================================================
	// Request detection
	logic [NUM_EXT-1:0] ext_hit;
	logic nmi_pin_hit;
	logic [NUM_NMI-1:0] nmi_evt;
	logic [NUM_SRC-1:0] src_hit;
	logic sw_hit;

	generate
		for (g = 0; g < NUM_EXT; g++) begin : g_det
			logic fall;
			logic rise;
			assign fall = pin_prev[g] & ~pin_lvl[g];
			assign rise = ~pin_prev[g] & pin_lvl[g];
			always_comb begin
				case (irq_mode[2*g +: 2])
					DET_LOW: ext_hit[g] = ~pin_lvl[g];
					DET_FALL: ext_hit[g] = fall;
					DET_RISE: ext_hit[g] = rise;
					default: ext_hit[g] = fall | rise;
				endcase
			end
		end
	endgenerate

	// NMI pin has only the two single-edge choices
	assign nmi_pin_hit = nmi_rise ?
		(~pin_prev[NMI_PIN] & pin_lvl[NMI_PIN]) :
		(pin_prev[NMI_PIN] & ~pin_lvl[NMI_PIN]);

	assign nmi_evt[NMIF_PIN] = nmi_pin_hit;
	assign nmi_evt[NMIF_OSC] = osc_stop_in;
	assign nmi_evt[NMIF_WDOG] = independent_watchdog_err_in;
	assign nmi_evt[NMIF_VMON1] = volt_mon1_in;
	assign nmi_evt[NMIF_VMON2] = volt_mon2_in;

	assign sw_hit = wr_en && avs_address_in == OFS_SW_TRIG
		&& avs_byteenable_in[0] && avs_writedata_in[0];
	assign src_hit = {sw_hit, periph_req_in, ext_hit};

	// ==========================================================
	// Sticky flags, set wins over a write-one clear
	logic nmi_clr_wr;
	logic pend_clr_wr;
	logic exc_clr_wr;
	logic [3:0] exc_evt;

	assign nmi_clr_wr = wr_en && avs_address_in == OFS_NMI_FLAGS;
	assign pend_clr_wr = wr_en && avs_address_in == OFS_PEND;
	assign exc_clr_wr = wr_en && avs_address_in == OFS_EXC_FLAGS;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			nmi_flags <= '0;
		end else begin
			nmi_flags <= (nmi_flags
				& ~(nmi_clr_wr ? wbits[NUM_NMI-1:0] : '0))
				| nmi_evt;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend <= '0;
		end else begin
			pend <= (pend & ~(pend_clr_wr ? wbits[NUM_SRC-1:0] : '0))
				| src_hit;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			exc_flags <= 4'h0;
		end else begin
			exc_flags <= (exc_flags & ~(exc_clr_wr ? wbits[3:0] : 4'h0))
				| exc_evt;
		end
	end

	// Level view of maskable events, gated by the enable mask
	assign irq_out = |(pend & enable);

	// ==========================================================
	// Non-maskable request, no mask or level applies
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			nmi_req_out <= '0;
		end else begin
			nmi_req_out.valid <= |nmi_flags;
			nmi_req_out.vector <= VEC_NMI;
		end
	end

	// ==========================================================
	// Maskable ranking
	always_comb begin
		next_irq = '0;
		// Strict greater keeps the lowest index on a tie
		for (int i = 0; i < NUM_SRC; i++) begin
			if (pend[i] && enable[i] && (!next_irq.valid
				|| prio[i] > next_irq.level)) begin
				next_irq.valid = 1'b1;
				next_irq.id = 5'(i);
				next_irq.level = prio[i];
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_req_out <= '0;
		end else begin
			irq_req_out <= next_irq;
		end
	end

	// ==========================================================
	// Core exceptions
	logic priv_fault;

	// Privileged opcode only faults in user mode
	assign priv_fault = priv_instr_in & user_mode_in;
	assign exc_evt[EXCF_INT] = trap_instr_in;
	assign exc_evt[EXCF_BRK] = breakpoint_trap_instr_in;
	assign exc_evt[EXCF_UNDEF] = undef_instr_in;
	assign exc_evt[EXCF_PRIV] = priv_fault;

	// One pulse per event; undefined beats privileged beats traps
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			exc_req_out <= '0;
		end else begin
			exc_req_out.valid <= |exc_evt;
			if (undef_instr_in) begin
				exc_req_out.vector <= VEC_UNDEF;
			end else if (priv_fault) begin
				exc_req_out.vector <= VEC_PRIV;
			end else if (breakpoint_trap_instr_in) begin
				exc_req_out.vector <= VEC_BRK;
			end else if (trap_instr_in) begin
				exc_req_out.vector <= VEC_TRAP_BASE
					| {2'h0, trap_num_in};
			end else begin
				exc_req_out.vector <= 6'h00;
			end
		end
	end

endmodule : irc_top

// File: logic/irc_pkg.sv
// Constants and carrier types of the interrupt request controller
// Functional notes
// - Five non-maskable sources ignore mask and priority
// - Sources: pin, osc stop, watchdog, two monitors
// - Eight external pins plus peripheral requests
// - One software request, handled as maskable
// - Sixteen priority levels rank maskable requests
// - Digital filter needs three equal samples
// - Filter clock: divide by 1, 8, 32, 64
// - Filter enable per pin, else raw level
// - External pins detect low level
// - External pins detect both edges
// - NMI pin and external pins: falling edge
// - Rising edge; NMI pin edges only
// - INT and break traps; sixteen trap vectors
// - Undefined and privileged instruction exceptions
// - NMI vector lies in exception table
package irc_pkg;
	localparam int NUM_EXT = 8;
	localparam int NUM_PER = 8;
	localparam int NUM_SRC = 17;
	localparam int SW_SRC = 16;
	localparam int NUM_NMI = 5;
	localparam int NUM_PIN = 9;
	localparam int NMI_PIN = 8;
	// Byte addresses of the registers
	localparam logic [7:0] OFS_NMI_FLAGS = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_FILT_EN = 8'h08;
	localparam logic [7:0] OFS_IRQ_MODE = 8'h0C;
	localparam logic [7:0] OFS_PEND = 8'h10;
	localparam logic [7:0] OFS_ENABLE = 8'h14;
	localparam logic [7:0] OFS_SW_TRIG = 8'h18;
	localparam logic [7:0] OFS_PRIO0 = 8'h1C;
	localparam logic [7:0] OFS_PRIO1 = 8'h20;
	localparam logic [7:0] OFS_PRIO2 = 8'h24;
	localparam logic [7:0] OFS_ACTIVE = 8'h28;
	localparam logic [7:0] OFS_EXC_FLAGS = 8'h2C;
	// Field positions
	localparam int NMIF_PIN = 0;
	localparam int NMIF_OSC = 1;
	localparam int NMIF_WDOG = 2;
	localparam int NMIF_VMON1 = 3;
	localparam int NMIF_VMON2 = 4;
	localparam int CFG_NMI_RISE = 0;
	localparam int CFG_DIV_LSB = 1;
	localparam int ACT_VALID = 9;
	localparam int ACT_LVL_LSB = 5;
	localparam int EXCF_INT = 0;
	localparam int EXCF_BRK = 1;
	localparam int EXCF_UNDEF = 2;
	localparam int EXCF_PRIV = 3;
	// Detection modes of an external pin
	localparam logic [1:0] DET_LOW = 2'h0;
	localparam logic [1:0] DET_FALL = 2'h1;
	localparam logic [1:0] DET_RISE = 2'h2;
	localparam logic [1:0] DET_BOTH = 2'h3;
	// Filter clock divide limits (divide minus one)
	localparam logic [5:0] DIV_LIM_1 = 6'h00;
	localparam logic [5:0] DIV_LIM_8 = 6'h07;
	localparam logic [5:0] DIV_LIM_32 = 6'h1F;
	localparam logic [5:0] DIV_LIM_64 = 6'h3F;
	localparam int FILT_SAMPLES = 3;
	// Exception vector table entries
	localparam logic [5:0] VEC_TRAP_BASE = 6'h00;
	localparam logic [5:0] VEC_BRK = 6'h10;
	localparam logic [5:0] VEC_UNDEF = 6'h11;
	localparam logic [5:0] VEC_PRIV = 6'h12;
	localparam logic [5:0] VEC_NMI = 6'h13;
	// Reset values
	localparam logic [1:0] RST_MODE = DET_FALL;
	localparam logic [3:0] RST_PRIO = 4'h0;
	typedef struct packed {
		logic valid;
		logic [4:0] id;
		logic [3:0] level;
	} irc_irq_req_t;
	typedef struct packed {
		logic valid;
		logic [5:0] vector;
	} irc_exc_req_t;
endpackage : irc_pkg

// File: dv/irc_chk.sv
// Assertion checker bound to the controller top
`timescale 1ns/1ps
module irc_chk
	import irc_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	input wire logic osc_stop_in,
	input wire logic trap_instr_in,
	input wire logic [3:0] trap_num_in,
	input wire logic breakpoint_trap_instr_in,
	input wire logic undef_instr_in,
	input wire logic priv_instr_in,
	input wire logic user_mode_in,
	input wire logic irq_out,
	input wire irc_irq_req_t irq_req_out,
	input wire irc_exc_req_t nmi_req_out,
	input wire irc_exc_req_t exc_req_out
);
	logic flt;
	logic breakpoint_trap_instr;
	assign flt = priv_instr_in && user_mode_in;
	assign breakpoint_trap_instr = breakpoint_trap_instr_in;
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// ====
	// Bus and requests
	a_one_wait: assert property ((avs_read_in || avs_write_in) &&
		avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("more than one wait cycle");
	a_req_track: assert property (
		1'b1 |=> irq_req_out.valid == $past(irq_out))
		else $error("request valid off irq level");
	// ====
	// Non-maskable
	a_nmi_vector: assert property (
		nmi_req_out.valid |-> nmi_req_out.vector == VEC_NMI)
		else $error("nmi vector wrong");
	a_nmi_raise: assert property (
		osc_stop_in |-> ##[1:2] nmi_req_out.valid)
		else $error("nmi not raised");
	a_nmi_sticky: assert property (
		nmi_req_out.valid && !avs_write_in && !$past(avs_write_in)
		|=> nmi_req_out.valid) else $error("nmi flag lost");
	// ====
	// Exceptions
	a_trap_vec: assert property (
		trap_instr_in && !breakpoint_trap_instr && !undef_instr_in && !flt |=>
		exc_req_out == {1'b1, 2'h0, $past(trap_num_in)})
		else $error("trap vector wrong");
	a_brk_vec: assert property (
		breakpoint_trap_instr && !undef_instr_in && !flt |=>
		exc_req_out == {1'b1, VEC_BRK}) else $error("break vector wrong");
	a_undef_vec: assert property (
		undef_instr_in |=> exc_req_out == {1'b1, VEC_UNDEF})
		else $error("undefined vector wrong");
	a_priv_vec: assert property (
		flt && !undef_instr_in |=> exc_req_out == {1'b1, VEC_PRIV})
		else $error("privilege vector wrong");
endmodule : irc_chk

bind irc_top irc_chk u_irc_chk (
	.ref_clk_in,
	.rst_n_in,
	.avs_read_in,
	.avs_write_in,
	.avs_waitrequest_out,
	.osc_stop_in,
	.trap_instr_in,
	.trap_num_in,
	.breakpoint_trap_instr_in,
	.undef_instr_in,
	.priv_instr_in,
	.user_mode_in,
	.irq_out,
	.irq_req_out,
	.nmi_req_out,
	.exc_req_out
);

// File: dv/irc_core_model.sv
// Model of the pins and processor core facing the controller
`timescale 1ns/1ps
module irc_core_model
	import irc_pkg::*;
(
	input wire logic ref_clk_in,
	output logic [NUM_PIN-1:0] pin_out,
	output logic [3:0] nmi_evt_out,
	output logic [4:0] core_evt_out,
	output logic [3:0] trap_num_out
);
	// Pins idle high so a reset leaves no edge behind
	initial begin
		pin_out = 9'h1FF;
		nmi_evt_out = 4'h0;
		core_evt_out = 5'h00;
		trap_num_out = 4'h0;
	end
	task automatic pins(input logic [NUM_PIN-1:0] v);
		@(posedge ref_clk_in);
		pin_out <= v;
	endtask : pins
	// One-cycle event; number is garbled once released
	task automatic pulse(input logic [8:0] ev, input logic [3:0] n);
		@(posedge ref_clk_in);
		{nmi_evt_out, core_evt_out} <= ev;
		trap_num_out <= n;
		@(posedge ref_clk_in);
		{nmi_evt_out, core_evt_out} <= 9'h000;
		trap_num_out <= ~n;
	endtask : pulse
endmodule : irc_core_model

// File: dv/irc_top_bench.sv
// Self-checking bench of the interrupt request controller
`timescale 1ns/1ps
module irc_top_bench
	import irc_pkg::*;
;
	typedef struct packed {
		logic [1:0] m;
		logic v0;
		logic v1;
		logic e;
	} irc_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic we = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hF;
	logic [7:0] preq = 8'h00;
	logic [31:0] rdat;
	logic wreq;
	logic irq;
	irc_irq_req_t ireq;
	irc_exc_req_t nreq;
	irc_exc_req_t ereq;
	logic [8:0] pins;
	logic [3:0] nev;
	logic [4:0] cev;
	logic [3:0] tnum;
	logic [8:0] pv;
	logic [31:0] q;
	irc_row_t r;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	int dv [4] = '{1, 8, 32, 64};
	irc_row_t rows [8] = '{'{DET_FALL, 1'b1, 1'b0, 1'b1},
		'{DET_FALL, 1'b0, 1'b1, 1'b0}, '{DET_RISE, 1'b0, 1'b1, 1'b1},
		'{DET_RISE, 1'b1, 1'b0, 1'b0}, '{DET_BOTH, 1'b1, 1'b0, 1'b1},
		'{DET_BOTH, 1'b0, 1'b1, 1'b1}, '{DET_LOW, 1'b0, 1'b0, 1'b1},
		'{DET_LOW, 1'b1, 1'b1, 1'b0}};
	always #2 clk = ~clk;
	irc_top u_irc_top (
		.ref_clk_in(clk),
		.rst_n_in(rst_n),
		.avs_address_in(adr),
		.avs_read_in(rd),
		.avs_write_in(we),
		.avs_writedata_in(wd),
		.avs_byteenable_in(be),
		.avs_readdata_out(rdat),
		.avs_waitrequest_out(wreq),
		.ext_req_pin_in(pins[7:0]),
		.nmi_pin_in(pins[8]),
		.osc_stop_in(nev[3]),
		.independent_watchdog_err_in(nev[2]),
		.volt_mon1_in(nev[1]),
		.volt_mon2_in(nev[0]),
		.periph_req_in(preq),
		.trap_instr_in(cev[4]),
		.trap_num_in(tnum),
		.breakpoint_trap_instr_in(cev[3]),
		.undef_instr_in(cev[2]),
		.priv_instr_in(cev[1]),
		.user_mode_in(cev[0]),
		.irq_out(irq),
		.irq_req_out(ireq),
		.nmi_req_out(nreq),
		.exc_req_out(ereq)
	);
	irc_core_model u_irc_core_model (
		.ref_clk_in(clk),
		.pin_out(pins),
		.nmi_evt_out(nev),
		.core_evt_out(cev),
		.trap_num_out(tnum)
	);
	// ====
	// Tasks
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	// Request stands until the edge that samples waitrequest low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] b = 4'hF);
		@(posedge clk);
		adr <= a;
		wd <= d;
		be <= b;
		we <= w;
		rd <= !w;
		do
			@(posedge clk);
		while (wreq !== 1'b0);
		q = rdat;
		we <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			wrap_up();
		end
	end
	// ====
	// Sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			r = rows[i];
			bus(1, OFS_IRQ_MODE, {16{r.m}});
			pv = {1'b1, {8{r.v0}}};
			u_irc_core_model.pins(pv);
			repeat (8) @(posedge clk);
			bus(1, OFS_PEND, 32'h1FFFF);
			pv[i] = r.v1;
			u_irc_core_model.pins(pv);
			repeat (8) @(posedge clk);
			bus(0, OFS_PEND, 32'h0);
			chk("pend", {31'h0, r.e}, {31'h0, q[i]});
			u_irc_core_model.pins(9'h1FF);
		end
		$display("test detection done");
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		bus(0, OFS_IRQ_MODE, 32'h0);
		chk("mode", 32'h5555, q);
		bus(0, OFS_ENABLE, 32'h0);
		chk("enable", 32'h0, q);
		bus(0, 8'hFC, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("test reset done");
		bus(1, OFS_ENABLE, 32'h1FFFF);
		bus(1, OFS_PRIO1, 32'h0050_0540);
		bus(1, OFS_PRIO2, 32'h0000_000F);
		@(posedge clk) preq <= 8'h26;
		@(posedge clk) preq <= 8'h00;
		repeat (4) @(posedge clk);
		#1;
		chk("best", {22'h0, 1'b1, 5'h0A, 4'h5}, {22'h0, ireq});
		bus(1, OFS_SW_TRIG, 32'h1);
		repeat (3) @(posedge clk);
		#1;
		chk("soft", {22'h0, 1'b1, 5'h10, 4'hF}, {22'h0, ireq});
		bus(1, OFS_ENABLE, 32'h0);
		#1;
		chk("masked", 32'h0, {31'h0, irq});
		bus(1, OFS_ENABLE, 32'h1FFFF);
		bus(1, OFS_PEND, 32'h1FFFF);
		#1;
		chk("cleared", 32'h0, {31'h0, irq});
		bus(1, OFS_PRIO0, 32'hFFFF_FFFF, 4'h1);
		bus(0, OFS_PRIO0, 32'h0);
		chk("lanes", 32'h0000_00FF, q);
		$display("test priority done");
		u_irc_core_model.pins(9'h0FF);
		u_irc_core_model.pulse(9'h1E0, 4'h0);
		repeat (8) @(posedge clk);
		bus(0, OFS_NMI_FLAGS, 32'h0);
		chk("nmi flags", 32'h1F, q);
		chk("nmi vec", {25'h0, 1'b1, VEC_NMI}, {25'h0, nreq});
		bus(1, OFS_NMI_FLAGS, 32'h1F);
		bus(0, OFS_NMI_FLAGS, 32'h0);
		chk("nmi clear", 32'h0, q);
		bus(1, OFS_CFG, 32'h1);
		u_irc_core_model.pins(9'h1FF);
		repeat (8) @(posedge clk);
		bus(0, OFS_NMI_FLAGS, 32'h0);
		chk("nmi rise", 32'h1, q);
		$display("test nmi done");
		for (int n = 0; n < 16; n++) begin
			u_irc_core_model.pulse(9'h010, n[3:0]);
			#1;
			chk("trap vec", {25'h0, 1'b1, 2'h0, n[3:0]},
				{25'h0, ereq});
		end
		u_irc_core_model.pulse(9'h008, 4'h0);
		#1;
		chk("brk vec", {25'h0, 1'b1, VEC_BRK},
			{25'h0, ereq});
		u_irc_core_model.pulse(9'h002, 4'h0);
		#1;
		chk("no fault", 32'h0, {25'h0, ereq});
		u_irc_core_model.pulse(9'h004, 4'h0);
		#1;
		chk("undef vec", {25'h0, 1'b1, VEC_UNDEF},
			{25'h0, ereq});
		u_irc_core_model.pulse(9'h003, 4'h0);
		u_irc_core_model.pulse(9'h01F, 4'h0);
		u_irc_core_model.pulse(9'h00B, 4'h0);
		bus(0, OFS_EXC_FLAGS, 32'h0);
		chk("exc flags", 32'hF, q);
		$display("test exceptions done");
		bus(1, OFS_FILT_EN, 32'h1);
		for (int d = 0; d < 4; d++) begin
			bus(1, OFS_CFG, {29'h0, d[1:0], 1'b0});
			bus(1, OFS_PEND, 32'h1FFFF);
			// Pin 0 low one tick only; unfiltered pin 1 sees it
			u_irc_core_model.pins(9'h1FC);
			repeat (dv[d] - 1) @(posedge clk);
			u_irc_core_model.pins(9'h1FF);
			repeat (4 * dv[d] + 8) @(posedge clk);
			bus(0, OFS_PEND, 32'h0);
			chk("glitch", 32'h0, {31'h0, q[0]});
			chk("bypass", 32'h1, {31'h0, q[1]});
			u_irc_core_model.pins(9'h1FE);
			repeat (4 * dv[d] + 8) @(posedge clk);
			bus(0, OFS_PEND, 32'h0);
			chk("filtered", 32'h1, {31'h0, q[0]});
			u_irc_core_model.pins(9'h1FF);
			repeat (4 * dv[d] + 8) @(posedge clk);
		end
		$display("test filter done");
		wrap_up();
	end
endmodule : irc_top_bench
